// ===== core/aep_encoder.sv
`timescale 1ns/1ps
module aep_encoder
	import aep_pkg::*;
#(
	parameter longint PRESET_HOLD = aep_pkg::PRESET_CYCLES,
	parameter int     GAP_HOLD    = aep_pkg::GAP_CYCLES
) (
	// System
	input  wire logic                         clk_in,
	input  wire logic                         reset_in,
	// Shaft sensing, raw edge count, same domain
	input  wire logic [aep_pkg::POS_BITS-1:0] shaft_pos_in,
	input  wire logic                         internal_fault_in,
	// Non-volatile zero point, loaded at power-up
	input  wire logic [aep_pkg::POS_BITS-1:0] nv_zero_in,
	output aep_pkg::aep_nv_t                  nv_store_out,
	// Preset pin
	input  wire logic                         preset_in,
	// Incremental outputs
	output aep_pkg::aep_quad_t                quad_out,
	output aep_pkg::aep_hall_t                hall_out,
	// Serial link
	input  wire logic                         ssi_clk_in,
	output logic                              ssi_data_out
);
	import aep_pkg::*;

	// ********************************************
	// Parameter checks
	// ********************************************
	// Start bit goes ahead of the word, so the word is the link length
	if (FRAME_BITS != FRAME_LEN) begin : g_frame_chk
		$error("aep_encoder: frame word does not match link length");
	end

	// Bit counter must reach one past the last bit of the word
	if (FRAME_LEN + 1 != int'(FRAME_END)) begin : g_count_chk
		$error("aep_encoder: bit counter end does not fit the frame");
	end

	if (PRESET_HOLD < 1) begin : g_preset_chk
		$error("aep_encoder: preset hold must be at least one cycle");
	end

	// Gap counter is sixteen bits wide
	if (GAP_HOLD < 1 || GAP_HOLD > 65535) begin : g_gap_chk
		$error("aep_encoder: gap hold out of counter range");
	end

	// Index and sector logic assume a power-of-two turn
	if (EDGES_PER_REV != (1 << REV_BITS) || REV_BITS >= POS_BITS) begin : g_rev_chk
		$error("aep_encoder: turn length unsupported");
	end

	// ********************************************
	// Declarations
	// ********************************************
	// System clock domain
	logic [POS_BITS-1:0]  zero_ff;
	logic                 loaded_ff;
	logic [1:0]           preset_sync_ff;
	logic [63:0]          preset_cnt_ff;
	logic                 preset_done_ff;
	logic                 preset_hit;
	aep_nv_t              nv_ff;
	logic [POS_BITS-1:0]  rel_pos;
	logic [2:0]           sector;
	aep_quad_t            quad_ff;
	aep_hall_t            hall_ff;
	logic                 fault_ff;
	logic [FRAME_LEN-1:0] snap_ff;
	logic [1:0]           busy_sync_ff;
	logic [15:0]          gap_cnt_ff;
	logic                 gap_done_ff;

	// Link clock domain
	logic                 link_busy_ff;
	logic [FRAME_LEN-1:0] shift_ff;
	logic [BIT_CNT_W-1:0] bit_cnt_ff;
	logic                 data_ff;

	// ********************************************
	// Decoding helpers
	// ********************************************
	// Gray order 00 10 11 01 on rising count: A ahead of B
	function automatic logic chan_a(input logic [1:0] p);
		return p[1] ^ p[0];
	endfunction

	function automatic logic chan_b(input logic [1:0] p);
		return p[1];
	endfunction

	// One count wide, in the 00 state, so it starts on a B edge on rising count and on an A edge on falling count
	function automatic logic at_index(input logic [POS_BITS-1:0] p);
		return (p[REV_BITS-1:0] == '0);
	endfunction

	// Ten pole pairs, six sectors each: sixty sectors per turn
	function automatic logic [2:0] hall_sector(input logic [POS_BITS-1:0] p);
		logic [POS_BITS+5:0] scaled;
		scaled = {6'h00, p} * 23'h00003c;
		return 3'((scaled >> REV_BITS) % 23'h000006);
	endfunction

	// Hall one flips at sectors 0 and 3, the back-EMF crossings
	function automatic aep_hall_t hall_levels(input logic [2:0] s);
		aep_hall_t h;
		h.hall_sense_one   = (s < 3'h3);
		h.hall_sense_two   = (s >= 3'h2) && (s < 3'h5);
		h.hall_sense_three = (s >= 3'h4) || (s < 3'h1);
		return h;
	endfunction

	// Word after the start bit: position, zero bits, ok flag (low on fault)
	function automatic logic [FRAME_LEN-1:0] frame_word(
		input logic [POS_BITS-1:0] p,
		input logic                ok
	);
		return {p, {ZERO_BITS{1'b0}}, ok};
	endfunction

	// ********************************************
	// Zero point
	// ********************************************
	// Zero taken only once after reset: a new preset waits for power-up
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			zero_ff   <= ZERO_RESET;
			loaded_ff <= 1'b0;
		end else if (!loaded_ff) begin
			zero_ff   <= nv_zero_in;
			loaded_ff <= 1'b1;
		end
	end

	assign rel_pos = shaft_pos_in - zero_ff;

	// ********************************************
	// Preset
	// ********************************************
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			preset_sync_ff <= 2'h0;
		end else begin
			preset_sync_ff <= {preset_sync_ff[0], preset_in};
		end
	end

	// Counter restarts on any drop, so short pulses never store
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			preset_cnt_ff <= 64'h0;
		end else if (!preset_sync_ff[1]) begin
			preset_cnt_ff <= 64'h0;
		end else if (preset_cnt_ff < 64'(PRESET_HOLD - 1)) begin
			preset_cnt_ff <= preset_cnt_ff + 64'h1;
		end
	end

	assign preset_hit = preset_sync_ff[1] && !preset_done_ff &&
		(preset_cnt_ff >= 64'(PRESET_HOLD - 1));

	// One store per hold: the pin must drop before another one
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			preset_done_ff <= 1'b0;
		end else if (!preset_sync_ff[1]) begin
			preset_done_ff <= 1'b0;
		end else if (preset_hit) begin
			preset_done_ff <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			nv_ff <= '0;
		end else begin
			nv_ff.wr <= preset_hit;
			if (preset_hit) begin
				nv_ff.pos <= shaft_pos_in;
			end
		end
	end

	assign nv_store_out = nv_ff;

	// ********************************************
	// Incremental channels
	// ********************************************
	assign sector = hall_sector(rel_pos);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			quad_ff <= '0;
		end else begin
			quad_ff.a     <= chan_a(rel_pos[1:0]);
			quad_ff.a_n   <= ~chan_a(rel_pos[1:0]);
			quad_ff.b     <= chan_b(rel_pos[1:0]);
			quad_ff.b_n   <= ~chan_b(rel_pos[1:0]);
			quad_ff.idx   <= at_index(rel_pos);
			quad_ff.idx_n <= ~at_index(rel_pos);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			hall_ff <= '0;
		end else begin
			hall_ff <= hall_levels(sector);
		end
	end

	assign quad_out = quad_ff;
	assign hall_out = hall_ff;

	// ********************************************
	// Snapshot handed to the link domain
	// ********************************************
	// Fault is sticky: one glitch marks every later frame until reset
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fault_ff <= 1'b0;
		end else begin
			fault_ff <= fault_ff | internal_fault_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			busy_sync_ff <= 2'h0;
		end else begin
			busy_sync_ff <= {busy_sync_ff[0], link_busy_ff};
		end
	end

	// Word is taken raw at the first falling host edge; a bit that
	// changes in that instant may be caught old or new
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			snap_ff <= '0;
		end else if (!busy_sync_ff[1]) begin
			snap_ff <= frame_word(rel_pos, ~fault_ff);
		end
	end

	// ********************************************
	// Gap between frames
	// ********************************************
	// Gap measured in clk_in cycles from the end of the last frame
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gap_cnt_ff <= 16'h0;
		end else if (busy_sync_ff[1]) begin
			gap_cnt_ff <= 16'h0;
		end else if (gap_cnt_ff < 16'(GAP_HOLD)) begin
			gap_cnt_ff <= gap_cnt_ff + 16'h1;
		end
	end

	// Registered so the link domain never sees a compare glitch
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			gap_done_ff <= 1'b0;
		end else begin
			gap_done_ff <= !busy_sync_ff[1] && (gap_cnt_ff >= 16'(GAP_HOLD));
		end
	end

	// ********************************************
	// Serial link domain
	// ********************************************
	// Host clock idles high and may be stopped at reset, so the link
	// registers clear asynchronously. A frame cut short stays open
	// until the host clocks it to the end.
	always_ff @(negedge ssi_clk_in or posedge reset_in) begin
		if (reset_in) begin
			link_busy_ff <= 1'b0;
			shift_ff     <= '0;
		end else if (!link_busy_ff && gap_done_ff) begin
			shift_ff     <= snap_ff;
			link_busy_ff <= 1'b1;
		end else if (link_busy_ff && bit_cnt_ff == FRAME_END) begin
			link_busy_ff <= 1'b0;
		end
	end

	// Rising edge 1 sends the start bit, edges 2 to 24 the word
	always_ff @(posedge ssi_clk_in or posedge reset_in) begin
		if (reset_in) begin
			bit_cnt_ff <= '0;
			data_ff    <= 1'b1;
		end else if (!link_busy_ff) begin
			bit_cnt_ff <= '0;
			data_ff    <= 1'b1;
		end else if (bit_cnt_ff == '0) begin
			data_ff    <= 1'b1;
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end else if (bit_cnt_ff < FRAME_END) begin
			data_ff    <= shift_ff[FRAME_END - 5'h01 - bit_cnt_ff];
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end
	end

	assign ssi_data_out = data_ff;
endmodule

// ===== core/aep_pkg.sv
package aep_pkg;
	// ********************************************
	// Resolution and frame layout
	// ********************************************
	localparam int CYCLES_PER_REV  = 4096;
	localparam int EDGES_PER_REV   = 4 * CYCLES_PER_REV;
	localparam int POS_BITS        = 17;
	localparam int ZERO_BITS       = 5;
	localparam int REV_BITS        = 14;
	// Start bit is sent ahead of the word and is not part of it
	localparam int FRAME_BITS      = POS_BITS + ZERO_BITS + 1;
	localparam int FRAME_LEN       = 23;
	localparam int BIT_CNT_W       = 5;
	localparam logic [BIT_CNT_W-1:0] FRAME_END = 5'h18;
	localparam int CLK_HZ          = 20000000;
	localparam int GAP_TIME_US     = 20;
	localparam int GAP_CYCLES      = (GAP_TIME_US * CLK_HZ + 999999) / 1000000;
	localparam int PRESET_TIME_S   = 3;
	localparam longint PRESET_CYCLES = longint'(PRESET_TIME_S) * longint'(CLK_HZ);
	localparam logic [POS_BITS-1:0] ZERO_RESET = 17'h00000;

	// ********************************************
	// Carriers
	// ********************************************
	typedef struct packed {
		logic a;
		logic a_n;
		logic b;
		logic b_n;
		logic idx;
		logic idx_n;
	} aep_quad_t;

	typedef struct packed {
		logic hall_sense_one;
		logic hall_sense_two;
		logic hall_sense_three;
	} aep_hall_t;

	// Storage of the zero point that survives power-down
	typedef struct packed {
		logic                wr;
		logic [POS_BITS-1:0] pos;
	} aep_nv_t;
endpackage

// ===== verification/aep_encoder_assertions.sv
`timescale 1ns/1ps
// ****************************
// Encoder port checks
// ****************************
module aep_encoder_assertions
	import aep_pkg::*;
(
	input wire logic                         clk_in,
	input wire logic                         reset_in,
	input wire logic [aep_pkg::POS_BITS-1:0] shaft_pos_in,
	input wire logic                         preset_in,
	input wire aep_pkg::aep_nv_t             nv_store_out,
	input wire aep_pkg::aep_quad_t           quad_out,
	input wire aep_pkg::aep_hall_t           hall_out
);
	logic [2:0]          rst_d_ff;
	logic [POS_BITS-1:0] pos_d_ff;
	logic                step_ok_ff;
	// Outputs settle two edges after release, once the zero is loaded
	always_ff @(posedge clk_in) rst_d_ff <= {rst_d_ff[1:0], reset_in};
	// Channel order only means something when the shaft moved one count
	always_ff @(posedge clk_in) pos_d_ff <= shaft_pos_in;
	always_ff @(posedge clk_in) step_ok_ff <= (shaft_pos_in - pos_d_ff) inside {17'h00000, 17'h00001, 17'h1ffff};
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in || (|rst_d_ff));
	chk_a_pair: assert property (quad_out.a_n == !quad_out.a) else $error("a pair");
	chk_b_idx_pair: assert property (quad_out.b_n == !quad_out.b && quad_out.idx_n == !quad_out.idx)
		else $error("b or index pair");
	chk_quarter_step: assert property (step_ok_ff && $changed(quad_out.a) |-> $stable(quad_out.b))
		else $error("a and b moved together");
	chk_idx_on_b: assert property (quad_out.idx |-> !quad_out.a && !quad_out.b)
		else $error("index off b edge");
	chk_hall_order: assert property (step_ok_ff && $changed(hall_out.hall_sense_one) |-> $stable(hall_out[1:0]))
		else $error("hall lines moved together");
	chk_store_pulse: assert property (nv_store_out.wr |=> !nv_store_out.wr)
		else $error("store pulse too long");
	chk_preset_held: assert property (nv_store_out.wr |-> $past(preset_in, 4))
		else $error("store without preset");
	chk_store_pos: assert property (nv_store_out.wr |-> nv_store_out.pos == $past(shaft_pos_in, 1))
		else $error("stored position wrong");
	cover property (nv_store_out.wr);
	cover property ($rose(quad_out.idx));
	cover property ($changed(hall_out.hall_sense_one));
endmodule
bind aep_encoder aep_encoder_assertions aep_encoder_assertions_i (.clk_in(clk_in),
	.reset_in(reset_in), .shaft_pos_in(shaft_pos_in), .preset_in(preset_in),
	.nv_store_out(nv_store_out), .quad_out(quad_out), .hall_out(hall_out));

// ===== verification/aep_encoder_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: mismatch", $time); end end
// ****************************
// Encoder bench
// ****************************
module aep_encoder_tb_top;
	import aep_pkg::*;
	logic clk_in = 1'b0, reset_in = 1'b1, preset_in = 1'b0, internal_fault_in = 1'b0;
	logic [POS_BITS-1:0] shaft_pos_in = 17'h0, nv_zero_in = 17'h0, zero;
	logic start = 1'b0, done, ssi_clk, ssi_data;
	logic [23:0] frame_w;
	aep_nv_t nv_store_out;
	aep_quad_t quad_out;
	aep_hall_t hall_out;
	int error_cnt = 0, n_tests = 0;
	always #25 clk_in = ~clk_in;
	aep_encoder #(.PRESET_HOLD(100), .GAP_HOLD(10)) aep_encoder_i (.clk_in(clk_in),
		.reset_in(reset_in), .shaft_pos_in(shaft_pos_in), .internal_fault_in(internal_fault_in),
		.nv_zero_in(nv_zero_in), .nv_store_out(nv_store_out), .preset_in(preset_in),
		.quad_out(quad_out), .hall_out(hall_out), .ssi_clk_in(ssi_clk), .ssi_data_out(ssi_data));
	aep_ssi_host aep_ssi_host_i (.start_in(start), .done_out(done), .frame_out(frame_w),
		.ssi_clk_out(ssi_clk), .ssi_data_in(ssi_data));
	task automatic tick(int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic frame(logic [16:0] shaft, logic [16:0] pos, logic ok);
		int k;
		shaft_pos_in <= shaft;
		tick(20);
		start <= 1'b1;
		tick(4);
		start <= 1'b0;
		shaft_pos_in <= ~shaft;
		for (k = 0; k < 50 && done !== 1'b1; k++) tick(1);
		if (k == 50) error_cnt++;
		else `CHK(frame_w, {1'b1, pos, 5'h00, ok})
		$display("frame test done");
	endtask
	task automatic spin(logic [16:0] step, int n, logic b_at_a, int idx_exp);
		int na, ni;
		logic a0, i0;
		na = 0;
		ni = 0;
		@(negedge clk_in) {a0, i0} = {quad_out.a, quad_out.idx};
		repeat (n) begin
			@(posedge clk_in) shaft_pos_in <= shaft_pos_in + step;
			@(posedge clk_in);
			@(negedge clk_in);
			if (quad_out.a === 1'b1 && a0 === 1'b0) begin na++; `CHK(quad_out.b, b_at_a) end
			if (quad_out.idx === 1'b1 && i0 === 1'b0) begin ni++; `CHK(hall_out, 3'h5) end
			{a0, i0} = {quad_out.a, quad_out.idx};
		end
		`CHK(na, n / 4)
		`CHK(ni, idx_exp)
		$display("spin test done");
	endtask
	task automatic preset(int hold, int exp_wr);
		int nw;
		nw = 0;
		@(posedge clk_in);
		shaft_pos_in <= 17'h0abc8;
		preset_in <= 1'b1;
		for (int k = 0; k < hold + 20; k++) begin
			@(posedge clk_in) if (k == hold) preset_in <= 1'b0;
			@(negedge clk_in);
			if (nv_store_out.wr === 1'b1) begin nw++; zero = nv_store_out.pos; end
		end
		`CHK(nw, exp_wr)
		$display("preset test done");
	endtask
	initial begin
		tick(5);
		reset_in <= 1'b0;
		frame(17'h1ffff, 17'h1ffff, 1'b1);
		frame(17'h00001, 17'h00001, 1'b1);
		shaft_pos_in <= 17'h0;
		tick(4);
		spin(17'h00001, 16384, 1'b0, 1);
		spin(17'h1ffff, 64, 1'b1, 0);
		preset(50, 0);
		preset(120, 1);
		`CHK(zero, 17'h0abc8)
		tick(1);
		nv_zero_in <= zero;
		reset_in <= 1'b1;
		tick(5);
		reset_in <= 1'b0;
		frame(17'h0abcd, 17'h00005, 1'b1);
		internal_fault_in <= 1'b1;
		frame(17'h0abc9, 17'h00001, 1'b0);
		results;
	end
endmodule

// ===== verification/aep_ssi_host.sv
`timescale 1ns/1ps
// ****************************
// Host reading one serial frame
// ****************************
module aep_ssi_host (
	// Control
	input  wire logic start_in,
	output logic      done_out,
	output logic [23:0] frame_out,
	// Link
	output logic      ssi_clk_out,
	input  wire logic ssi_data_in
);
	initial begin
		ssi_clk_out = 1'b1;
		done_out = 1'b0;
		frame_out = 24'h0;
	end
	// Clock stands high between frames; read on each falling edge after the first
	always @(posedge start_in) begin
		done_out = 1'b0;
		#3;
		for (int i = 0; i < 25; i++) begin
			#7.5 ssi_clk_out = 1'b0;
			if (i > 0) frame_out = {frame_out[22:0], ssi_data_in};
			#7.5 ssi_clk_out = 1'b1;
		end
		done_out = 1'b1;
	end
endmodule
